// *** hw/mseq_sequencer.sv ***
// Multi segment position sequencer: segment table, trigger handling,
// segment stepping and idle timing, with a plain register port.
// Assumes trigger, select and direction inputs already synchronous to
// ref_clk, and a profile generator that pulses motion_done per move.
module mseq_sequencer #(
    parameter int MS_CYCLES = mseq_pkg::MS_CYCLES
) (
    input  wire logic              ref_clk,              // 100 MHz control clock
    input  wire logic              rst,                  // Sync reset, active high
    input  wire logic [11:0]       addr,                 // Register byte address
    input  wire logic [31:0]       wdata,                // Register write data
    input  wire logic              wr,                   // Write strobe
    input  wire logic              rd,                   // Read strobe
    output logic [31:0]            rdata,                // Read data, cycle after rd
    input  wire logic              sequence_trigger_in,  // Start/stop trigger level
    input  wire logic              segment_select_bit0,  // Segment select weight 1
    input  wire logic              segment_select_bit1,  // Segment select weight 2
    input  wire logic              segment_select_bit2,  // Segment select weight 4
    input  wire logic              segment_select_bit3,  // Segment select weight 8
    input  wire logic              direction_reverse_in, // Negate targets when high
    input  wire logic              homed_in,             // Origin return completed
    input  wire logic              motion_done,          // Profile finished, pulse
    output mseq_pkg::mseq_cmd_t    cmd,                  // Segment command
    output logic                   cmd_valid,            // Command strobe, one cycle
    output logic                   running,              // Sequence active
    output logic                   fault                 // Homing fault, sticky
);

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic signed [31:0]    pulse_mem [16];
    logic [15:0]           speed_mem [16];
    logic [15:0]           ramp_mem  [16];
    logic [15:0]           idle_mem  [16];

    logic [1:0]            trig_mode_ff;
    logic                  cycle_mode_ff;
    logic                  abs_mode_ff;
    logic [3:0]            last_seg_ff;
    logic [15:0]           ncc_ff;
    logic                  trig_prev_ff;
    logic [3:0]            seg_ff;
    logic signed [31:0]    pos_ff;
    mseq_pkg::mseq_state_t state_ff;
    logic [31:0]           ms_tick_ff;
    logic [15:0]           ms_left_ff;
    logic                  done_seen_ff;
    mseq_pkg::mseq_cmd_t   cmd_ff;
    logic                  cmd_valid_ff;
    logic                  fault_ff;
    logic [31:0]           rdata_ff;

    logic                  trig_rise;
    logic                  trig_fall;
    logic                  stop_req;
    logic [3:0]            sel_idx;
    logic [3:0]            nxt_seg;
    logic                  seq_end;
    logic                  idle_over;
    logic signed [31:0]    seg_target;
    logic signed [31:0]    nxt_pos;
    logic                  abs_blocked;
    logic                  seg_hit;
    logic [3:0]            wr_seg;
    logic [1:0]            wr_fld;
    logic                  clr_fault;

    // ------------------------------------------------------------
    // Trigger edges
    // ------------------------------------------------------------

    // Previous trigger level for edge detection
    // Clears low like an idle pin, so no false rise
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            trig_prev_ff <= 1'b0;
        end else begin
            trig_prev_ff <= sequence_trigger_in;
        end
    end

    // Falling edge stops only in modes 0 and 2; modes 1 and 3 ignore it
    // A fall in the issue cycle drops that command too
    assign trig_rise = sequence_trigger_in & ~trig_prev_ff;
    assign trig_fall = ~sequence_trigger_in & trig_prev_ff;
    assign stop_req  = trig_fall & ~trig_mode_ff[0];

    // Start segment from the weighted select inputs, index 0 is segment 1
    // Read once per start; later select changes are ignored
    assign sel_idx = {segment_select_bit3, segment_select_bit2,
                      segment_select_bit1, segment_select_bit0};

    // ------------------------------------------------------------
    // Segment arithmetic
    // ------------------------------------------------------------

    // Direction input flips the programmed count
    // Taken at issue, so a change hits later segments only
    assign seg_target = direction_reverse_in ? -pulse_mem[seg_ff]
                                             : pulse_mem[seg_ff];

    // Absolute counts from origin, relative adds to present position
    // Absolute moves drop the running position on purpose
    assign nxt_pos = abs_mode_ff ? seg_target : pos_ff + seg_target;

    // Absolute move without a finished origin return is refused
    assign abs_blocked = abs_mode_ff & ~homed_in;

    // Last configured segment ends a pass
    // A start above the last index runs to 15 first
    assign seq_end = (seg_ff == last_seg_ff);
    assign nxt_seg = seq_end ? 4'h0 : seg_ff + 4'h1;

    // Idle over once the per-segment millisecond count runs out
    assign idle_over = (ms_left_ff == 16'h0000);

    // ------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------
    assign seg_hit   = (addr >= mseq_pkg::SEG_BASE) && (addr <= mseq_pkg::SEG_END);
    assign wr_seg    = addr[7:4];
    assign wr_fld    = addr[3:2];
    assign clr_fault = wr && (addr == mseq_pkg::STATUS_OFS)
                       && wdata[mseq_pkg::STAT_FAULT_BIT];

    // Control register, writable at any time, takes effect at once
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            trig_mode_ff  <= mseq_pkg::TRIG_MODE_RST;
            cycle_mode_ff <= 1'b0;
            abs_mode_ff   <= 1'b0;
            last_seg_ff   <= mseq_pkg::LAST_SEG_RST;
        end else if (wr && addr == mseq_pkg::CTRL_OFS) begin
            trig_mode_ff  <= wdata[mseq_pkg::CTRL_TRIG_LSB +: 2];
            cycle_mode_ff <= wdata[mseq_pkg::CTRL_CYCLE_BIT];
            abs_mode_ff   <= wdata[mseq_pkg::CTRL_ABS_BIT];
            last_seg_ff   <= wdata[mseq_pkg::CTRL_LAST_LSB +: 4];
        end
    end

    // Next-command condition; only bit 0 steers the sequencer
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ncc_ff <= mseq_pkg::NCC_RST;
        end else if (wr && addr == mseq_pkg::NCC_OFS) begin
            ncc_ff <= wdata[15:0];
        end
    end

    // Segment table, four words per segment
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            for (int i = 0; i < 16; i++) begin
                pulse_mem[i] <= mseq_pkg::PULSE_RST;
                speed_mem[i] <= mseq_pkg::SPEED_RST;
                ramp_mem[i]  <= mseq_pkg::RAMP_RST;
                idle_mem[i]  <= mseq_pkg::IDLE_RST;
            end
        end else if (wr && seg_hit) begin
            case (wr_fld)
                2'h0: pulse_mem[wr_seg] <= wdata;
                2'h1: speed_mem[wr_seg] <= wdata[15:0];
                2'h2: ramp_mem[wr_seg]  <= wdata[15:0];
                default: idle_mem[wr_seg] <= wdata[15:0];
            endcase
        end
    end

    // Read data stands one cycle after the strobe; unmapped reads zero
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rdata_ff <= 32'h0000_0000;
        end else if (rd) begin
            if (addr == mseq_pkg::CTRL_OFS) begin
                rdata_ff <= {24'h00_0000, last_seg_ff, abs_mode_ff,
                             cycle_mode_ff, trig_mode_ff};
            end else if (addr == mseq_pkg::NCC_OFS) begin
                rdata_ff <= {16'h0000, ncc_ff};
            end else if (addr == mseq_pkg::STATUS_OFS) begin
                rdata_ff <= {24'h00_0000, seg_ff, 1'b0, done_seen_ff, fault_ff,
                             (state_ff != mseq_pkg::ST_IDLE)};
            end else if (addr == mseq_pkg::POSITION_OFS) begin
                rdata_ff <= pos_ff;
            end else if (seg_hit) begin
                case (wr_fld)
                    2'h0: rdata_ff <= pulse_mem[wr_seg];
                    2'h1: rdata_ff <= {16'h0000, speed_mem[wr_seg]};
                    2'h2: rdata_ff <= {16'h0000, ramp_mem[wr_seg]};
                    default: rdata_ff <= {16'h0000, idle_mem[wr_seg]};
                endcase
            end else begin
                rdata_ff <= 32'h0000_0000;
            end
        end else begin
            rdata_ff <= 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------
    // Sequencer state machine
    // ------------------------------------------------------------

    // Stepping through segments; select inputs are read only on a rise
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_ff <= mseq_pkg::ST_IDLE;
            seg_ff   <= 4'h0;
        end else if (stop_req) begin
            state_ff <= mseq_pkg::ST_IDLE;
        end else begin
            case (state_ff)
                mseq_pkg::ST_IDLE: begin
                    if (trig_rise) begin
                        state_ff <= mseq_pkg::ST_ISSUE;
                        seg_ff   <= sel_idx;
                    end
                end
                mseq_pkg::ST_ISSUE: begin
                    if (abs_blocked) begin
                        state_ff <= mseq_pkg::ST_IDLE;
                    end else if (ncc_ff[0]) begin
                        state_ff <= mseq_pkg::ST_WAIT_IDLE;
                    end else begin
                        state_ff <= mseq_pkg::ST_WAIT_DONE;
                    end
                end
                mseq_pkg::ST_WAIT_DONE: begin
                    if (motion_done) begin
                        state_ff <= mseq_pkg::ST_WAIT_IDLE;
                    end
                end
                default: begin
                    if (idle_over) begin
                        if (seq_end && !cycle_mode_ff) begin
                            state_ff <= mseq_pkg::ST_IDLE;
                        end else begin
                            state_ff <= mseq_pkg::ST_ISSUE;
                            seg_ff   <= nxt_seg;
                        end
                    end
                end
            endcase
        end
    end

    // Idle timer: loaded per segment, counts milliseconds down
    // Reloads outside the wait, so a stop leaves no stale count
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ms_left_ff <= 16'h0000;
            ms_tick_ff <= 32'h0000_0000;
        end else if (state_ff != mseq_pkg::ST_WAIT_IDLE) begin
            ms_left_ff <= idle_mem[seg_ff];
            ms_tick_ff <= 32'h0000_0000;
        end else if (!idle_over) begin
            if (ms_tick_ff == 32'(MS_CYCLES - 1)) begin
                ms_tick_ff <= 32'h0000_0000;
                ms_left_ff <= ms_left_ff - 16'h0001;
            end else begin
                ms_tick_ff <= ms_tick_ff + 32'h0000_0001;
            end
        end
    end

    // Done flag kept only for visibility of a pending completion
    // Shown in status bit 2 for software polling
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            done_seen_ff <= 1'b0;
        end else if (state_ff == mseq_pkg::ST_ISSUE) begin
            done_seen_ff <= 1'b0;
        end else if (motion_done) begin
            done_seen_ff <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Command output and commanded position
    // ------------------------------------------------------------

    // One command strobe per segment, with that segment's own profile
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cmd_valid_ff <= 1'b0;
            cmd_ff       <= '0;
        end else if (state_ff == mseq_pkg::ST_ISSUE && !abs_blocked
                     && !stop_req) begin
            cmd_valid_ff   <= 1'b1;
            cmd_ff.target  <= nxt_pos;
            cmd_ff.speed   <= speed_mem[seg_ff];
            cmd_ff.ramp_ms <= ramp_mem[seg_ff];
        end else begin
            cmd_valid_ff <= 1'b0;
        end
    end

    // Commanded position follows each issued segment
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pos_ff <= 32'h0000_0000;
        end else if (state_ff == mseq_pkg::ST_ISSUE && !abs_blocked
                     && !stop_req) begin
            pos_ff <= nxt_pos;
        end
    end

    // Fault is sticky; a new fault in the clearing cycle wins
    // A refused start returns to idle; a new rise is needed
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            fault_ff <= 1'b0;
        end else if (state_ff == mseq_pkg::ST_ISSUE && abs_blocked
                     && !stop_req) begin
            fault_ff <= 1'b1;
        end else if (clr_fault) begin
            fault_ff <= 1'b0;
        end
    end

    // Running flag registered so the port comes from a flip-flop
    // Trails the state by one cycle
    logic running_ff;
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            running_ff <= 1'b0;
        end else begin
            running_ff <= (state_ff != mseq_pkg::ST_IDLE);
        end
    end

    // ------------------------------------------------------------
    // Output ports
    // ------------------------------------------------------------
    assign rdata     = rdata_ff;
    assign cmd       = cmd_ff;
    assign cmd_valid = cmd_valid_ff;
    assign running   = running_ff;
    assign fault     = fault_ff;

endmodule

// *** hw/mseq_pkg.sv ***
// Constants, types and register map of the multi segment position sequencer.
// Assumes a single 100 MHz control clock and a synchronous active-high reset.
package mseq_pkg;

    // ------------------------------------------------------------
    // Register map, byte addresses of 32-bit words
    // ------------------------------------------------------------
    localparam logic [11:0] CTRL_OFS     = 12'h000;
    localparam logic [11:0] NCC_OFS      = 12'h004;
    localparam logic [11:0] STATUS_OFS   = 12'h008;
    localparam logic [11:0] POSITION_OFS = 12'h00c;
    localparam logic [11:0] SEG_BASE     = 12'h100;
    localparam logic [11:0] SEG_END      = 12'h1ff;

    // Field positions inside CTRL and STATUS
    localparam int CTRL_TRIG_LSB  = 0;
    localparam int CTRL_CYCLE_BIT = 2;
    localparam int CTRL_ABS_BIT   = 3;
    localparam int CTRL_LAST_LSB  = 4;
    localparam int STAT_RUN_BIT   = 0;
    localparam int STAT_FAULT_BIT = 1;
    localparam int STAT_SEG_LSB   = 4;

    // Values after reset
    localparam logic [1:0]  TRIG_MODE_RST = 2'h3;
    localparam logic [15:0] NCC_RST       = 16'h0000;
    localparam logic [3:0]  LAST_SEG_RST  = 4'h0;
    localparam logic [31:0] PULSE_RST     = 32'h0000_2710;
    localparam logic [15:0] SPEED_RST     = 16'h01f4;
    localparam logic [15:0] RAMP_RST      = 16'h01f4;
    localparam logic [15:0] IDLE_RST      = 16'h0001;

    // Idle time unit and clock rate
    localparam int IDLE_UNIT_NS  = 1000000;
    localparam int CLK_PERIOD_NS = 10;
    localparam int MS_CYCLES     = IDLE_UNIT_NS / CLK_PERIOD_NS;

    // Sequencer states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ISSUE,
        ST_WAIT_DONE,
        ST_WAIT_IDLE
    } mseq_state_t;

    // One segment command handed to the profile generator
    typedef struct packed {
        logic signed [31:0] target;
        logic [15:0]        speed;
        logic [15:0]        ramp_ms;
    } mseq_cmd_t;

endpackage

// *** sim/mseq_sequencer_sva.sv ***
// Port checker for the multi segment position sequencer.
// Assumes one control clock and a synchronous active-high reset.
module mseq_sequencer_sva #(
    parameter int MS_CYCLES = 10
) (
    input wire logic                ref_clk,             // Control clock
    input wire logic                rst,                 // Sync reset
    input wire logic [11:0]         addr,                // Register address
    input wire logic [31:0]         wdata,               // Register write data
    input wire logic                wr,                  // Write strobe
    input wire logic                sequence_trigger_in, // Trigger level
    input wire logic                homed_in,            // Origin return done
    input wire mseq_pkg::mseq_cmd_t cmd,                 // Segment command
    input wire logic                cmd_valid,           // Command strobe
    input wire logic                running,             // Sequence active
    input wire logic                fault                // Homing fault
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);

    // ------------------------------------------------------------
    // Starting a run
    // ------------------------------------------------------------
    start_on_rise_a: assert property ($rose(sequence_trigger_in) && !running
        |-> ##2 (cmd_valid || fault))
        else $error("trigger rise did not start a run");
    first_cmd_cause_a: assert property (cmd_valid && !$past(running)
        |-> $past(sequence_trigger_in, 2) && !$past(sequence_trigger_in, 3))
        else $error("run started without a trigger rise");
    // ------------------------------------------------------------
    // Command strobe and payload
    // ------------------------------------------------------------
    cmd_pulse_a: assert property (cmd_valid |=> !cmd_valid)
        else $error("command strobe longer than one cycle");
    cmd_hold_a: assert property ($changed(cmd) |-> cmd_valid)
        else $error("command changed without strobe");
    cmd_running_a: assert property (cmd_valid |-> running)
        else $error("command issued while not running");
    stop_quiet_a: assert property ($fell(running) |-> !cmd_valid [*2])
        else $error("command issued at end of run");
    // ------------------------------------------------------------
    // Homing fault
    // ------------------------------------------------------------
    fault_sticky_a: assert property (fault
        && !(wr && addr == mseq_pkg::STATUS_OFS && wdata[1]) |=> fault)
        else $error("fault cleared without write");
    fault_cause_a: assert property ($rose(fault) |-> !$past(homed_in) && !cmd_valid)
        else $error("fault raised while homed");

    // Main scenarios reached
    cover property (cmd_valid ##[1:100] cmd_valid);
    cover property ($rose(fault));
    cover property ($fell(running));
endmodule

bind mseq_sequencer mseq_sequencer_sva #(.MS_CYCLES(MS_CYCLES)) u_sva (
    .ref_clk(ref_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
    .sequence_trigger_in(sequence_trigger_in), .homed_in(homed_in), .cmd(cmd),
    .cmd_valid(cmd_valid), .running(running), .fault(fault)
);

// *** sim/mseq_ctrl_model.sv ***
// External controller and profile stand-in for the segment sequencer.
// Assumes the bench changes requests by non-blocking assignment.
module mseq_ctrl_model #(
    parameter int DONE_LAT = 40
) (
    input  wire logic       ref_clk,              // Control clock
    input  wire logic       go,                   // Requested trigger level
    input  wire logic [3:0] sel,                  // Requested segment index
    input  wire logic       rev,                  // Requested reverse level
    input  wire logic       homed,                // Origin return state
    input  wire logic       cmd_valid,            // Issued segment strobe
    output logic            sequence_trigger_in,  // Trigger pin level
    output logic [3:0]      seg_sel,              // Select pins, bit per weight
    output logic            direction_reverse_in, // Reverse pin level
    output logic            homed_in,             // Homing status
    output logic            motion_done           // Move finished pulse
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt_ff;

    // Input pins follow the requests, level driven by the controller
    assign sequence_trigger_in  = go;
    assign seg_sel              = sel;
    assign direction_reverse_in = rev;
    assign homed_in             = homed;
    // Two-state counter, so done is defined from time zero
    assign motion_done          = (cnt_ff == 1);

    // Each move takes DONE_LAT cycles; a new command restarts it
    always_ff @(posedge ref_clk) begin
        if (cmd_valid) begin
            cnt_ff <= DONE_LAT;
        end else if (cnt_ff != 0) begin
            cnt_ff <= cnt_ff - 1;
        end
    end
endmodule

// *** sim/mseq_sequencer_bench.sv ***
// Self-checking bench for the segment sequencer.
// Assumes a 100 MHz clock and the idle unit shortened to MSC cycles.
module mseq_sequencer_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int MSC  = 10;
    localparam int DLAT = 40;
    logic                ref_clk, rst, wr, rd, go, rev, homed;
    logic                trig, dir, homed_in, motion_done, cmd_valid, running, fault;
    logic [11:0]         addr;
    logic [31:0]         wdata, rdata;
    logic [3:0]          sel, seg_sel;
    mseq_pkg::mseq_cmd_t cmd;
    int                  n_fail, checked, cyc, last_t, gap;

    mseq_sequencer #(.MS_CYCLES(MSC)) u_dut (
        .ref_clk(ref_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .sequence_trigger_in(trig), .segment_select_bit0(seg_sel[0]),
        .segment_select_bit1(seg_sel[1]), .segment_select_bit2(seg_sel[2]),
        .segment_select_bit3(seg_sel[3]), .direction_reverse_in(dir), .homed_in(homed_in),
        .motion_done(motion_done), .cmd(cmd), .cmd_valid(cmd_valid), .running(running),
        .fault(fault)
    );
    mseq_ctrl_model #(.DONE_LAT(DLAT)) u_ctrl (
        .ref_clk(ref_clk), .go(go), .sel(sel), .rev(rev), .homed(homed),
        .cmd_valid(cmd_valid), .sequence_trigger_in(trig), .seg_sel(seg_sel),
        .direction_reverse_in(dir), .homed_in(homed_in), .motion_done(motion_done)
    );

    // Clock and a cycle count for spacing checks
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) cyc <= cyc + 1;

    // ------------------------------------------------------------
    // Reporting and comparison
    // ------------------------------------------------------------
    task automatic final_report();
        $display("checked=%0d n_fail=%0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t: value %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_flag(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t: flag %b, expected %b", $time, got, exp);
        end
    endtask
    task automatic timeout_fail();
        n_fail++;
        $display("ERROR %0t: wait timed out", $time);
        final_report();
    endtask

    // ------------------------------------------------------------
    // Register port and sequence helpers
    // ------------------------------------------------------------
    task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge ref_clk);
        wr    <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        @(posedge ref_clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge ref_clk);
        rd   <= 1'b0;
        @(negedge ref_clk);
        chk(rdata, exp);
    endtask
    task automatic seg(input int k, input logic [31:0] p, input logic [31:0] idle);
        logic [11:0] b;
        b = mseq_pkg::SEG_BASE + 12'(16 * k);
        wr_reg(b, p);
        wr_reg(b + 12'h004, 32'h0000_0064 + 32'(k));
        wr_reg(b + 12'h008, 32'h0000_0032);
        wr_reg(b + 12'h00c, idle);
    endtask
    task automatic wait_cmd(input logic [31:0] tgt, input logic [15:0] spd);
        int i;
        i = 0;
        do begin
            @(negedge ref_clk);
            i++;
        end while (cmd_valid !== 1'b1 && i < 600);
        if (i >= 600) timeout_fail();
        gap = cyc - last_t;
        last_t = cyc;
        chk(cmd.target, tgt);
        chk({16'h0000, cmd.speed}, {16'h0000, spd});
        chk({16'h0000, cmd.ramp_ms}, 32'h0000_0032);
        @(posedge ref_clk);
    endtask
    task automatic wait_idle();
        int i;
        i = 0;
        while (running !== 1'b0 && i < 400) begin
            @(negedge ref_clk);
            i++;
        end
        if (i >= 400) timeout_fail();
        @(posedge ref_clk);
    endtask
    // Window that must stay free of commands
    task automatic no_cmd(input int n);
        logic seen;
        seen = 1'b0;
        repeat (n) begin
            @(negedge ref_clk);
            seen = seen | cmd_valid;
        end
        chk_flag(seen, 1'b0);
        @(posedge ref_clk);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {rst, homed} = 2'b11;
        {wr, rd, go, rev} = 4'h0;
        addr = 12'h000;
        wdata = 32'h0000_0000;
        sel = 4'h0;
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        // Reset values, read-only and unmapped places
        rd_chk(mseq_pkg::CTRL_OFS, 32'h0000_0003);
        rd_chk(mseq_pkg::NCC_OFS, 32'h0000_0000);
        rd_chk(mseq_pkg::SEG_BASE, 32'h0000_2710);
        rd_chk(mseq_pkg::SEG_BASE + 12'h00c, 32'h0000_0001);
        wr_reg(mseq_pkg::POSITION_OFS, 32'h1234_5678);
        rd_chk(mseq_pkg::POSITION_OFS, 32'h0000_0000);
        rd_chk(12'h010, 32'h0000_0000);
        // Relative, mode 1, single run, early command condition
        seg(0, 32'd1000, 32'd2);
        seg(1, 32'd2000, 32'd2);
        wr_reg(mseq_pkg::CTRL_OFS, 32'h0000_0011);
        wr_reg(mseq_pkg::NCC_OFS, 32'h0000_0001);
        go <= 1'b1;
        wait_cmd(32'd1000, 16'h0064);
        go <= 1'b0;
        wait_cmd(32'd3000, 16'h0065);
        chk_flag(gap >= 2 * MSC && gap < DLAT, 1'b1);
        wait_idle();
        no_cmd(30);
        // Segment two reversed from position 3000
        rev <= 1'b1;
        sel <= 4'h1;
        go  <= 1'b1;
        wait_cmd(32'd1000, 16'h0065);
        wait_idle();
        go  <= 1'b0;
        rev <= 1'b0;
        rd_chk(mseq_pkg::POSITION_OFS, 32'h0000_03e8);
        // Every select code once, trigger modes 0 to 3 in turn, absolute and homed
        for (int k = 0; k < 16; k++) seg(k, 32'd100 * 32'(k + 1), 32'd0);
        for (int k = 0; k < 16; k++) begin
            wr_reg(mseq_pkg::CTRL_OFS, 32'h0000_0008 | 32'(k % 4) | 32'(k << 4));
            sel <= 4'(k);
            go  <= 1'b1;
            wait_cmd(32'd100 * 32'(k + 1), 16'h0064 + 16'(k));
            wait_idle();
            sel <= ~4'(k);
            no_cmd(20);
            go  <= 1'b0;
        end
        // Absolute start before homing, then clear
        homed <= 1'b0;
        wr_reg(mseq_pkg::CTRL_OFS, 32'h0000_0009);
        sel <= 4'h0;
        go  <= 1'b1;
        no_cmd(6);
        go  <= 1'b0;
        rd_chk(mseq_pkg::STATUS_OFS, 32'h0000_0002);
        chk_flag(fault, 1'b1);
        wr_reg(mseq_pkg::STATUS_OFS, 32'h0000_0002);
        repeat (2) @(negedge ref_clk);
        chk_flag(fault, 1'b0);
        // Cycle run, mode 0, wait for motion done
        seg(0, 32'd1000, 32'd1);
        homed <= 1'b1;
        seg(1, 32'd2000, 32'd1);
        wr_reg(mseq_pkg::NCC_OFS, 32'h0000_0000);
        wr_reg(mseq_pkg::CTRL_OFS, 32'h0000_001c);
        go <= 1'b1;
        wait_cmd(32'd1000, 16'h0064);
        wait_cmd(32'd2000, 16'h0065);
        chk_flag(gap >= DLAT + MSC - 1, 1'b1);
        wait_cmd(32'd1000, 16'h0064);
        go <= 1'b0;
        no_cmd(120);
        chk_flag(running, 1'b0);
        final_report();
    end
endmodule
